// >>> src/fce_seq.sv
// Operation
// - failures set error bit 6 or 7
// - bad command sequence sets both flags
// - bad second-cycle data sets both flags
// - escape code discards confirm-type command, no error
// - locked block erase gives erase error only
// - failed automatic erase gives erase error
// - failed programming sets program flag only
// - failed lock bit write gives program error
// - lock-disable suppresses locked erase error
// - display areas never raise lock errors
// - erase flag bit 7, program bit 6
// - clear status zeroes both flags
// - separate control register per area
`timescale 1ns/1ps
`default_nettype none

module fce_seq #(
  parameter int NUM_BLOCKS = 16
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // flash array engine
  input  wire logic        fa_done,
  input  wire logic        fa_fail,
  output fce_pkg::fce_fa_req_t fa_req,
  // interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the lock word holds sixteen bits, so no more blocks than that
  if (NUM_BLOCKS < 1 || NUM_BLOCKS > 16) begin : g_chk
    $error("NUM_BLOCKS must be 1 to 16");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // area code 3 is not a real area; fold it onto the user area
  function automatic logic [1:0] area_idx(input logic [1:0] a);
    area_idx = (a == 2'h3) ? 2'h0 : a;
  endfunction

  // one area control word: ready, lock-disable, flags
  function automatic logic [31:0] area_word(input logic e, input logic p,
                                            input logic ld, input logic rdy);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[fce_pkg::ERASE_BIT]   = e;
    w[fce_pkg::PROG_BIT]    = p;
    w[fce_pkg::LOCKDIS_BIT] = ld;
    w[fce_pkg::READY_BIT]   = rdy;
    area_word = w;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fce_pkg::fce_st_t r_reg;   // registered state
  fce_pkg::fce_st_t r_next;  // next state

  logic       acc;       // access completes at this edge
  logic       wr_cmd;    // completed write to command word
  logic [7:0] code;      // command code of this bus cycle
  logic [1:0] ar;        // target area of this bus cycle
  logic [3:0] blk;       // target block of this bus cycle
  logic       locked;    // latched target counts as locked
  logic       rdy;       // sequencer not busy

  assign acc    = psel & penable & r_reg.pready;
  assign wr_cmd = acc & pwrite & (paddr == fce_pkg::ADDR_CMD);
  assign code   = pwdata[fce_pkg::CODE_LSB +: 8];
  assign ar     = area_idx(pwdata[fce_pkg::AREA_LSB +: 2]);
  assign blk    = pwdata[fce_pkg::BLK_LSB +: 4];
  assign rdy    = (r_reg.state != fce_pkg::FCE_BUSY);
  // lock protection only in the user area and while enabled
  assign locked = ~r_reg.lock[r_reg.block] & ~r_reg.lock_dis
                & (r_reg.area == 2'h0);

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    r_next          = r_reg;
    r_next.fa.start = 1'b0;
    r_next.pready   = 1'b0;
    r_next.pslverr  = 1'b0;

    // apb: one wait state so every answer comes from a flop
    if (psel && penable && !r_reg.pready) begin
      r_next.pready = 1'b1;
      r_next.prdata = 32'h0000_0000;
      if (paddr == fce_pkg::ADDR_CMD) begin
        r_next.prdata = 32'h0000_0000;
      end else if (paddr == fce_pkg::ADDR_USER) begin
        r_next.prdata = area_word(r_reg.erase_f[0], r_reg.prog_f[0],
                                  r_reg.lock_dis, rdy);
      end else if (paddr == fce_pkg::ADDR_DISP1) begin
        r_next.prdata = area_word(r_reg.erase_f[1], r_reg.prog_f[1],
                                  1'b0, rdy);
      end else if (paddr == fce_pkg::ADDR_DISP2) begin
        r_next.prdata = area_word(r_reg.erase_f[2], r_reg.prog_f[2],
                                  1'b0, rdy);
      end else if (paddr == fce_pkg::ADDR_LOCK) begin
        r_next.prdata = {16'h0000, r_reg.lock};
      end else if (paddr == fce_pkg::ADDR_IRQ) begin
        r_next.prdata = {30'h0000_0000, r_reg.irq_st};
      end else if (paddr == fce_pkg::ADDR_MASK) begin
        r_next.prdata = {30'h0000_0000, r_reg.irq_mask};
      end else begin
        r_next.pslverr = 1'b1; // unmapped
      end
    end

    // plain register writes and read-to-clear
    if (acc && pwrite && paddr == fce_pkg::ADDR_USER) begin
      r_next.lock_dis = pwdata[fce_pkg::LOCKDIS_BIT];
    end
    if (acc && pwrite && paddr == fce_pkg::ADDR_MASK) begin
      r_next.irq_mask = pwdata[1:0];
    end
    // clear first so an event in the same cycle still sets
    if (acc && !pwrite && paddr == fce_pkg::ADDR_IRQ) begin
      r_next.irq_st = 2'h0;
    end

    // command sequencer
    case (r_reg.state)
      fce_pkg::FCE_IDLE: begin
        if (wr_cmd) begin
          if (code == fce_pkg::CMD_CLR) begin
            r_next.erase_f[ar] = 1'b0;
            r_next.prog_f[ar]  = 1'b0;
          end else if (code == fce_pkg::CMD_RD_ARR ||
                       code == fce_pkg::CMD_RD_STAT) begin
            r_next.state = fce_pkg::FCE_IDLE; // mode only
          end else if (code == fce_pkg::CMD_PROG  ||
                       code == fce_pkg::CMD_ERASE ||
                       code == fce_pkg::CMD_ERASE_ALL ||
                       code == fce_pkg::CMD_LOCK) begin
            // refused silently while a flag is up
            if (!r_reg.erase_f[ar] && !r_reg.prog_f[ar]) begin
              r_next.state = fce_pkg::FCE_WAIT2;
              r_next.cmd1  = code;
              r_next.area  = ar;
              r_next.block = blk;
            end
          end else begin
            // any other first code is a sequence error
            r_next.erase_f[ar] = 1'b1;
            r_next.prog_f[ar]  = 1'b1;
          end
        end
      end

      fce_pkg::FCE_WAIT2: begin
        if (wr_cmd) begin
          r_next.state       = fce_pkg::FCE_IDLE;
          r_next.fa.area     = r_reg.area;
          r_next.fa.block    = r_reg.block;
          r_next.fa.data     = code;
          if (r_reg.cmd1 == fce_pkg::CMD_PROG) begin
            // second cycle carries the data byte
            if (locked) begin
              r_next.prog_f[r_reg.area] = 1'b1;
            end else begin
              r_next.state     = fce_pkg::FCE_BUSY;
              r_next.fa.start  = 1'b1;
              r_next.fa.op     = fce_pkg::OP_PROG;
            end
          end else if (code == fce_pkg::CMD_RD_ARR) begin
            r_next.state = fce_pkg::FCE_IDLE;
          end else if (code != fce_pkg::CMD_CONFIRM ||
                       {1'b0, r_reg.block} >= 5'(NUM_BLOCKS)) begin
            // compare one bit wider: sixteen blocks must not wrap to zero
            r_next.erase_f[r_reg.area] = 1'b1;
            r_next.prog_f[r_reg.area]  = 1'b1;
          end else if (r_reg.cmd1 == fce_pkg::CMD_ERASE) begin
            if (locked) begin
              r_next.erase_f[r_reg.area] = 1'b1;
            end else begin
              r_next.state    = fce_pkg::FCE_BUSY;
              r_next.fa.start = 1'b1;
              r_next.fa.op    = fce_pkg::OP_ERASE;
            end
          end else if (r_reg.cmd1 == fce_pkg::CMD_ERASE_ALL) begin
            // locked blocks are skipped by the engine, not flagged
            r_next.state    = fce_pkg::FCE_BUSY;
            r_next.fa.start = 1'b1;
            r_next.fa.op    = fce_pkg::OP_ERASE_ALL;
          end else if (r_reg.area != 2'h0) begin
            r_next.state = fce_pkg::FCE_IDLE; // no lock bits
          end else begin
            r_next.state    = fce_pkg::FCE_BUSY;
            r_next.fa.start = 1'b1;
            r_next.fa.op    = fce_pkg::OP_LOCK;
          end
        end
      end

      fce_pkg::FCE_BUSY: begin
        // bus commands are dropped until the engine reports back
        if (fa_done) begin
          r_next.state = fce_pkg::FCE_IDLE;
          r_next.irq_st[fce_pkg::IRQ_DONE] = 1'b1;
          if (fa_fail) begin
            if (r_reg.fa.op == fce_pkg::OP_ERASE ||
                r_reg.fa.op == fce_pkg::OP_ERASE_ALL) begin
              r_next.erase_f[r_reg.area] = 1'b1;
            end else begin
              // a bad lock bit write counts as a program error
              r_next.prog_f[r_reg.area] = 1'b1;
            end
          end else if (r_reg.area == 2'h0) begin
            // lock bits follow a good erase or lock write
            if (r_reg.fa.op == fce_pkg::OP_ERASE) begin
              r_next.lock[r_reg.block] = 1'b1;
            end else if (r_reg.fa.op == fce_pkg::OP_LOCK) begin
              r_next.lock[r_reg.block] = 1'b0;
            end else if (r_reg.fa.op == fce_pkg::OP_ERASE_ALL &&
                         r_reg.lock_dis) begin
              r_next.lock = fce_pkg::LOCK_RST;
            end
          end
        end
      end

      default: begin
        // unused state code: fall back to idle
        r_next.state = fce_pkg::FCE_IDLE;
      end
    endcase

    // any newly raised flag is an error event
    if ((r_next.erase_f & ~r_reg.erase_f) != 3'h0 ||
        (r_next.prog_f & ~r_reg.prog_f) != 3'h0) begin
      r_next.irq_st[fce_pkg::IRQ_ERR] = 1'b1;
    end
    r_next.irq = |(r_next.irq_st & r_next.irq_mask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset loads one constant word and nothing else
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= fce_pkg::ST_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state flops
  assign prdata  = r_reg.prdata;
  assign pready  = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign fa_req  = r_reg.fa;
  assign irq     = r_reg.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // one clock domain, so one default clock and reset for all checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic w2_cmd; // second cycle of a confirm-type command
  assign w2_cmd = wr_cmd && r_reg.state == fce_pkg::FCE_WAIT2
                && r_reg.cmd1 != fce_pkg::CMD_PROG;

  // a confirm code as first cycle marks the area with both flags
  a_bad_first: assert property (wr_cmd && r_reg.state == fce_pkg::FCE_IDLE
      && code == fce_pkg::CMD_CONFIRM
      |=> r_reg.erase_f[$past(ar)] && r_reg.prog_f[$past(ar)])
    else $error("bad first cycle not flagged");
  // junk in the confirm cycle marks both flags
  a_bad_second: assert property (w2_cmd && code == 8'h12
      |=> r_reg.erase_f[$past(r_reg.area)] && r_reg.prog_f[$past(r_reg.area)])
    else $error("bad second cycle not flagged");
  // escape drops the command and leaves the flags alone
  a_escape_quiet: assert property (w2_cmd && code == fce_pkg::CMD_RD_ARR
      |=> r_reg.state == fce_pkg::FCE_IDLE && $stable(r_reg.erase_f)
      && $stable(r_reg.prog_f) && !r_reg.fa.start)
    else $error("escape not discarded");
  // locked erase: erase flag up, program flag low, no engine start
  a_locked_erase: assert property (w2_cmd && code == fce_pkg::CMD_CONFIRM
      && r_reg.cmd1 == fce_pkg::CMD_ERASE && locked
      && {1'b0, r_reg.block} < 5'(NUM_BLOCKS)
      |=> r_reg.erase_f[0] && !r_reg.prog_f[0] && !r_reg.fa.start)
    else $error("locked erase not flagged");
  // failed program in a display area: program flag only
  a_fail_class: assert property (r_reg.state == fce_pkg::FCE_BUSY && fa_done
      && fa_fail && r_reg.fa.op == fce_pkg::OP_PROG && r_reg.area == 2'h2
      |=> r_reg.prog_f[2] && $stable(r_reg.erase_f))
    else $error("program failure misreported");
  // clear status drops both flags of the named area
  a_clr_status: assert property (wr_cmd && r_reg.state == fce_pkg::FCE_IDLE
      && code == fce_pkg::CMD_CLR && ar == 2'h2
      |=> !r_reg.erase_f[2] && !r_reg.prog_f[2] ##1 !r_reg.fa.start)
    else $error("clear status failed");
  // a flagged area turns the command away
  a_refuse_cmd: assert property (wr_cmd && r_reg.state == fce_pkg::FCE_IDLE
      && code == fce_pkg::CMD_ERASE && (r_reg.erase_f[ar] || r_reg.prog_f[ar])
      |=> r_reg.state == fce_pkg::FCE_IDLE [*2])
    else $error("command taken with flag up");
  // no lock bits in display areas: no start, no flag
  a_display_lock: assert property (w2_cmd && code == fce_pkg::CMD_CONFIRM
      && r_reg.cmd1 == fce_pkg::CMD_LOCK && r_reg.area != 2'h0
      && {1'b0, r_reg.block} < 5'(NUM_BLOCKS)
      |=> !r_reg.fa.start && $stable(r_reg.prog_f) && $stable(r_reg.lock))
    else $error("lock error in display area");
  // a status read drops the interrupt unless an event lands with it
  a_irq_clear: assert property (acc && !pwrite && paddr == fce_pkg::ADDR_IRQ
      && !(r_reg.state == fce_pkg::FCE_BUSY && fa_done) |=> !irq)
    else $error("interrupt kept after status read");
  // every access is answered for one cycle only
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  // the main scenarios the bench is meant to reach
  c_erase_run: cover property (r_reg.fa.start && r_reg.fa.op == fce_pkg::OP_ERASE
      ##[1:20] fa_done);
  c_seq_error: cover property (w2_cmd && code == 8'h12);
  c_escape: cover property (w2_cmd && code == fce_pkg::CMD_RD_ARR);
  c_lock_display: cover property (w2_cmd && code == fce_pkg::CMD_CONFIRM
      && r_reg.cmd1 == fce_pkg::CMD_LOCK && r_reg.area != 2'h0);
  c_refused: cover property (wr_cmd && r_reg.state == fce_pkg::FCE_IDLE
      && code == fce_pkg::CMD_ERASE && r_reg.prog_f[ar]);

endmodule

`default_nettype wire

// >>> inc/fce_pkg.sv
`default_nettype none

package fce_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD   = 8'h00; // command bus cycle
  localparam logic [7:0] ADDR_USER  = 8'h04; // user area control
  localparam logic [7:0] ADDR_DISP1 = 8'h08; // display area one
  localparam logic [7:0] ADDR_DISP2 = 8'h0c; // display area two
  localparam logic [7:0] ADDR_LOCK  = 8'h10; // lock bits, read only
  localparam logic [7:0] ADDR_IRQ   = 8'h14; // sticky events
  localparam logic [7:0] ADDR_MASK  = 8'h18; // event mask

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int READY_BIT  = 0; // sequencer ready
  localparam int LOCKDIS_BIT = 2; // lock protection off
  localparam int PROG_BIT   = 6; // program_status_flag
  localparam int ERASE_BIT  = 7; // erase_status_flag
  localparam int CODE_LSB   = 0; // command code in cmd word
  localparam int AREA_LSB   = 8; // target area in cmd word
  localparam int BLK_LSB    = 10; // target block in cmd word
  localparam int IRQ_DONE   = 0; // operation finished
  localparam int IRQ_ERR    = 1; // an error flag was raised

  // ----------------------------------------------------------------
  // command codes (low byte of a bus cycle)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_PROG    = 8'h40;
  localparam logic [7:0] CMD_ERASE   = 8'h20;
  localparam logic [7:0] CMD_ERASE_ALL = 8'ha7;
  localparam logic [7:0] CMD_LOCK    = 8'h77;
  localparam logic [7:0] CMD_CLR     = 8'h50;
  localparam logic [7:0] CMD_RD_STAT = 8'h70;
  localparam logic [7:0] CMD_RD_ARR  = 8'hff;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] LOCK_RST = 16'hffff; // all unlocked

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FCE_IDLE, FCE_WAIT2, FCE_BUSY} fce_state_t;
  typedef enum logic [1:0] {OP_PROG, OP_ERASE, OP_ERASE_ALL, OP_LOCK} fce_op_t;

  // request toward the flash array engine
  typedef struct packed {
    logic       start;
    fce_op_t    op;
    logic [1:0] area;
    logic [3:0] block;
    logic [7:0] data;
  } fce_fa_req_t;

  // whole state of the block
  typedef struct packed {
    fce_state_t  state;
    logic [7:0]  cmd1;
    logic [1:0]  area;
    logic [3:0]  block;
    logic [2:0]  erase_f;
    logic [2:0]  prog_f;
    logic        lock_dis;
    logic [15:0] lock;
    logic [1:0]  irq_st;
    logic [1:0]  irq_mask;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    fce_fa_req_t fa;
  } fce_st_t;

  localparam fce_st_t ST_RST = '{state: FCE_IDLE, cmd1: 8'h00, area: 2'h0,
    block: 4'h0, erase_f: 3'h0, prog_f: 3'h0, lock_dis: 1'b0, lock: LOCK_RST,
    irq_st: 2'h0, irq_mask: 2'h0, prdata: 32'h0000_0000, pready: 1'b0,
    pslverr: 1'b0, irq: 1'b0, fa: '{start: 1'b0, op: OP_PROG, area: 2'h0,
    block: 4'h0, data: 8'h00}};

endpackage

`default_nettype wire

// >>> verif/fce_fa_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// flash array engine model
// ----------------------------------------------------------------
module fce_fa_model (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // request from the sequencer
  input  wire fce_pkg::fce_fa_req_t fa_req,
  // behaviour chosen by the bench
  input  wire logic                 fail_en,
  input  wire logic [3:0]           delay,
  // answer
  output logic                      fa_done,
  output logic                      fa_fail
);
  logic [4:0] cnt; // cycles left, zero when idle

  // one operation at a time, answered delay+1 cycles after start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt     <= 5'h00;
      fa_done <= 1'b0;
      fa_fail <= 1'b0;
    end else begin
      fa_done <= 1'b0;
      fa_fail <= ~fa_fail; // meaningless outside done, so keep it moving
      if (fa_req.start) begin
        cnt <= {1'b0, delay} + 5'h01;
      end else if (cnt == 5'h01) begin
        fa_done <= 1'b1;
        fa_fail <= fail_en;
        cnt     <= 5'h00;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule

`default_nettype wire

// >>> verif/test_flash_command_error_status.sv
`timescale 1ns/1ps
`default_nettype none

module test_flash_command_error_status;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                 pclk, presetn, psel, penable, pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic                 pready, pslverr, err, fa_done, fa_fail, irq, fail_en;
  logic [3:0]           delay;
  fce_pkg::fce_fa_req_t fa_req;
  int                   failures, n_checks, n_start, s0;
  // expected control words: ready, program error, erase error, sequence error
  localparam logic [31:0] OK = 32'h0000_0001, PE = 32'h0000_0041;
  localparam logic [31:0] EE = 32'h0000_0081, SE = 32'h0000_00c1;

  fce_seq #(.NUM_BLOCKS(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fa_done(fa_done), .fa_fail(fa_fail), .fa_req(fa_req), .irq(irq));
  fce_fa_model engine (.pclk(pclk), .presetn(presetn), .fa_req(fa_req), .fail_en(fail_en),
    .delay(delay), .fa_done(fa_done), .fa_fail(fa_fail));

  // ----------------------------------------------------------------
  // clock, start counter, watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // counts engine starts so refusals can be seen
  always @(posedge pclk) begin
    if (fa_req.start === 1'b1) n_start <= n_start + 1;
  end
  // run needs well under a thousand cycles, so this only trips on a hang
  initial begin
    #300000;
    failures++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed wait assumed: the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  function automatic logic [7:0] aaddr(input logic [1:0] ar);
    return ar == 2'h1 ? fce_pkg::ADDR_DISP1 : ar == 2'h2 ? fce_pkg::ADDR_DISP2 : fce_pkg::ADDR_USER;
  endfunction
  task automatic cmd(input logic [1:0] ar, input logic [7:0] c, input logic [3:0] bk);
    apb(1'b1, fce_pkg::ADDR_CMD, {18'h0, bk, ar, c});
  endtask
  // polls the area's ready bit; bounded so a stuck sequencer is caught
  task automatic wait_ready(input logic [7:0] a);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, a, 32'h0);
      if (rd[fce_pkg::READY_BIT] === 1'b1) return;
    end
    chk(32'h0, 32'h1);
  endtask
  // two-cycle command, engine told whether to fail
  task automatic op(input logic [1:0] ar, input logic [7:0] c1, input logic [7:0] c2,
                    input logic [3:0] bk, input logic f);
    s0 = n_start;
    fail_en <= f;
    cmd(ar, c1, bk);
    cmd(ar, c2, bk);
    wait_ready(aaddr(ar));
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, fail_en, presetn} = '0;
    delay = 4'h1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(fce_pkg::ADDR_USER, OK);
    rc(fce_pkg::ADDR_DISP1, OK);
    rc(fce_pkg::ADDR_DISP2, OK);
    rc(fce_pkg::ADDR_LOCK, 32'h0000_ffff);
    rc(8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    // masked event keeps irq low, unmasking raises it, status read clears
    op(2'h0, fce_pkg::CMD_ERASE, fce_pkg::CMD_CONFIRM, 4'h3, 1'b0);
    chk(32'(n_start - s0), 32'h1);
    rc(fce_pkg::ADDR_USER, OK);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, fce_pkg::ADDR_MASK, 32'h3);
    rc(fce_pkg::ADDR_MASK, 32'h3);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rc(fce_pkg::ADDR_IRQ, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("test erase and irq done");
    // program failure, then refusal while flagged, then clear
    op(2'h0, fce_pkg::CMD_PROG, 8'ha5, 4'h3, 1'b1);
    rc(fce_pkg::ADDR_USER, PE);
    rc(fce_pkg::ADDR_IRQ, 32'h3);
    s0 = n_start;
    cmd(2'h0, fce_pkg::CMD_ERASE, 4'h3);
    rc(fce_pkg::ADDR_USER, PE);
    chk(32'(n_start - s0), 32'h0);
    cmd(2'h0, fce_pkg::CMD_CLR, 4'h0);
    rc(fce_pkg::ADDR_USER, OK);
    delay <= 4'hc;
    op(2'h0, fce_pkg::CMD_ERASE_ALL, fce_pkg::CMD_CONFIRM, 4'h0, 1'b1);
    rc(fce_pkg::ADDR_USER, EE);
    cmd(2'h0, fce_pkg::CMD_CLR, 4'h0);
    $display("test failures done");
    // lock block 5, then erase it in several settings
    op(2'h0, fce_pkg::CMD_LOCK, fce_pkg::CMD_CONFIRM, 4'h5, 1'b0);
    rc(fce_pkg::ADDR_LOCK, 32'h0000_ffdf);
    op(2'h1, fce_pkg::CMD_ERASE, fce_pkg::CMD_CONFIRM, 4'h5, 1'b0);
    rc(fce_pkg::ADDR_DISP1, OK);
    chk(32'(n_start - s0), 32'h1);
    chk({15'h0, fa_req}, {15'h0, 1'b0, 2'(fce_pkg::OP_ERASE), 2'h1, 4'h5, fce_pkg::CMD_CONFIRM});
    op(2'h0, fce_pkg::CMD_ERASE, fce_pkg::CMD_CONFIRM, 4'h5, 1'b0);
    rc(fce_pkg::ADDR_USER, EE);
    chk(32'(n_start - s0), 32'h0);
    cmd(2'h0, fce_pkg::CMD_CLR, 4'h0);
    apb(1'b1, fce_pkg::ADDR_USER, 32'h4);
    op(2'h0, fce_pkg::CMD_ERASE, fce_pkg::CMD_CONFIRM, 4'h5, 1'b0);
    rc(fce_pkg::ADDR_USER, 32'h0000_0005);
    rc(fce_pkg::ADDR_LOCK, 32'h0000_ffff);
    apb(1'b1, fce_pkg::ADDR_USER, 32'h0);
    op(2'h0, fce_pkg::CMD_LOCK, fce_pkg::CMD_CONFIRM, 4'h6, 1'b1);
    rc(fce_pkg::ADDR_USER, PE);
    cmd(2'h0, fce_pkg::CMD_CLR, 4'h0);
    // lock program in a display area is ignored quietly
    op(2'h1, fce_pkg::CMD_LOCK, fce_pkg::CMD_CONFIRM, 4'h4, 1'b0);
    rc(fce_pkg::ADDR_DISP1, OK);
    chk(32'(n_start - s0), 32'h0);
    rc(fce_pkg::ADDR_LOCK, 32'h0000_ffff);
    $display("test lock done");
    // escape and bad second cycle for each confirmed command
    for (int i = 0; i < 3; i++) begin
      op(2'h0, i == 0 ? fce_pkg::CMD_ERASE : i == 1 ? fce_pkg::CMD_ERASE_ALL : fce_pkg::CMD_LOCK,
         fce_pkg::CMD_RD_ARR, 4'h2, 1'b0);
      rc(fce_pkg::ADDR_USER, OK);
      chk(32'(n_start - s0), 32'h0);
      op(2'h0, i == 0 ? fce_pkg::CMD_ERASE : i == 1 ? fce_pkg::CMD_ERASE_ALL : fce_pkg::CMD_LOCK,
         8'h12, 4'h2, 1'b0);
      rc(fce_pkg::ADDR_USER, SE);
      chk(32'(n_start - s0), 32'h0);
      cmd(2'h0, fce_pkg::CMD_CLR, 4'h0);
    end
    cmd(2'h0, fce_pkg::CMD_CONFIRM, 4'h0);
    rc(fce_pkg::ADDR_USER, SE);
    cmd(2'h0, fce_pkg::CMD_CLR, 4'h0);
    $display("test sequence done");
    // flags of one area leave the others alone
    op(2'h2, fce_pkg::CMD_PROG, 8'h3c, 4'h1, 1'b1);
    rc(fce_pkg::ADDR_DISP2, PE);
    chk({15'h0, fa_req}, {15'h0, 1'b0, 2'(fce_pkg::OP_PROG), 2'h2, 4'h1, 8'h3c});
    rc(fce_pkg::ADDR_USER, OK);
    rc(fce_pkg::ADDR_DISP1, OK);
    cmd(2'h2, fce_pkg::CMD_CLR, 4'h0);
    rc(fce_pkg::ADDR_DISP2, OK);
    $display("test areas done");
    give_verdict();
  end
endmodule

`default_nettype wire
